// File: rtl/csp_pkg.sv
// Purpose: Constants and types for the capstan speed PWM block.
// Assumes: 125 MHz clk, synchronous active-low reset.
// Notes:   Behaviour summary below, tags used in the design files.
//
// Behaviour
// - Source is chosen from mode and override flag; override makes software the source.
// - Record-record mode without override drives a fixed 50% duty factor.
// - Software source uses the value written to the duty factor register.
// - Tristate bit set puts the speed output into high impedance.
// - Frequency regulation disabled with tape source means phase-only regulation.
// - PWM period is fixed at 41.66 us; only the high time varies.
// - Tape duty factor recomputed every 21.33 ms and held between updates.
// - Tape duty comes from frame arrival phase against an internal reference.
// - Duty rises with lateness, about 9% at 1.65 blocks early, 91% late.
// - Beyond two blocks of phase error the characteristic wraps as a sawtooth.
// - Phase error beyond plus or minus 8.8 ms is treated as invalid.
// - Deviation from 96000 bit/s below phase-only threshold gives pure phase control.
// - Deviation above frequency-only threshold holds output high or low by direction.
// - Deviation between thresholds gates frequency with phase half of the time.
// - Narrow band select picks 6%/9% thresholds when clear, 3%/4.5% when set.
// - During sleep the output level and drive state are frozen.
// - Reset takes the output out of high impedance and clears tristate.
package csp_pkg;

    localparam int  CLK_PERIOD_NS   = 8;
    localparam real PWM_PERIOD_US   = 41.66;
    localparam int  PWM_PERIOD_CYC  = $rtoi(PWM_PERIOD_US * 1000.0 / CLK_PERIOD_NS);
    localparam real UPDATE_MS       = 21.33;
    localparam int  UPDATE_CYC      = $rtoi(UPDATE_MS * 1000000.0 / CLK_PERIOD_NS);
    localparam real PHASE_LIMIT_MS  = 8.8;
    localparam int  PHASE_LIMIT_CYC = $rtoi(PHASE_LIMIT_MS * 1000000.0 / CLK_PERIOD_NS);

    localparam int NOMINAL_BPS  = 96000;
    localparam int NOMINAL_BITS = $rtoi(NOMINAL_BPS * UPDATE_MS / 1000.0);
    localparam int PTH_W_PM       = 60;
    localparam int FTH_W_PM       = 90;
    localparam int PTH_N_PM       = 30;
    localparam int FTH_N_PM       = 45;
    localparam int BIT_CNT_W      = 16;
    localparam logic [BIT_CNT_W-1:0] PTH_WIDE   = BIT_CNT_W'(NOMINAL_BITS * PTH_W_PM / 1000);
    localparam logic [BIT_CNT_W-1:0] FTH_WIDE   = BIT_CNT_W'(NOMINAL_BITS * FTH_W_PM / 1000);
    localparam logic [BIT_CNT_W-1:0] PTH_NARROW = BIT_CNT_W'(NOMINAL_BITS * PTH_N_PM / 1000);
    localparam logic [BIT_CNT_W-1:0] FTH_NARROW = BIT_CNT_W'(NOMINAL_BITS * FTH_N_PM / 1000);
    localparam logic [BIT_CNT_W-1:0] NOMINAL_CNT = BIT_CNT_W'(NOMINAL_BITS);

    localparam int DUTY_W = 8;
    localparam logic [DUTY_W-1:0] DUTY_HALF = 8'h80;
    localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h80;

    localparam int REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_DUTY   = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h8;

    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_OVR_BIT   = 2;
    localparam int CTRL_FREG_BIT  = 3;
    localparam int CTRL_NBAND_BIT = 4;
    localparam int CTRL_HIZ_BIT   = 5;

    localparam int STAT_DUTY_LSB  = 0;
    localparam int STAT_VALID_BIT = 8;
    localparam int STAT_CLASS_LSB = 9;
    localparam int STAT_FAST_BIT  = 11;
    localparam int STAT_OUT_BIT   = 12;
    localparam int STAT_OE_BIT    = 13;
    localparam int STAT_SLEEP_BIT = 14;

    typedef enum logic [1:0] {
        MODE_PLAY_PLAY     = 2'b00,
        MODE_PLAY_RECORD   = 2'b01,
        MODE_RECORD_RECORD = 2'b10,
        MODE_SPARE         = 2'b11
    } csp_mode_e;

    typedef enum logic [1:0] {
        DEV_PHASE_ONLY = 2'b00,
        DEV_MIXED      = 2'b01,
        DEV_FREQ_ONLY  = 2'b10
    } csp_dev_e;

endpackage

// File: rtl/csp_pwm.sv
// Purpose: Capstan speed PWM generator with phase and frequency regulation.
// Assumes: Frame and bit pins are asynchronous; software port is on clk.
// Notes:   Long counts are parameters so simulation can shorten them.
//
// Design decisions made here: the plain strobed port and the register offsets.
module csp_pwm
    import csp_pkg::*;
#(
    parameter int PWM_PERIOD  = PWM_PERIOD_CYC,
    parameter int UPDATE_PER  = UPDATE_CYC,
    parameter int PHASE_LIMIT = PHASE_LIMIT_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [REG_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    input  wire logic                  sleep_pin,
    input  wire logic                  frame_pin,
    input  wire logic                  bit_pin,
    output logic                       speed_out,
    output logic                       speed_oe
);
    localparam int PCNT_W = $clog2(PWM_PERIOD + 1);
    localparam int RCNT_W = $clog2(UPDATE_PER + 1);
    localparam int HALF   = UPDATE_PER / 2;
    // Reciprocal avoids a divider in the phase-to-duty map
    localparam longint RCP = (64'd1 << 38) / UPDATE_PER;
    localparam int RCP_W  = 40 - RCNT_W;

    logic [1:0]            mode_reg;
    logic                  cpu_duty_override;
    logic                  freq_regulation_enable;
    logic                  narrow_band_select;
    logic                  pwm_output_tristate;
    logic [DUTY_W-1:0]     duty_factor_register;
    logic [31:0]           rdata_next;

    logic                  sleep_s;
    logic                  frame_s;
    logic                  bit_s;
    logic                  frame_d_reg;
    logic                  bit_d_reg;
    logic                  frame_evt;
    logic                  bit_evt;

    logic [RCNT_W-1:0]     ref_cnt_reg;
    logic                  ref_wrap;
    logic [RCNT_W-1:0]     phase_x_reg;
    logic                  frame_seen_reg;
    logic                  phase_ok;
    logic [RCNT_W-1:0]     phase_x_next;
    logic [39:0]           duty_prod;
    logic [DUTY_W-1:0]     tape_duty_reg;
    logic                  phase_valid_reg;

    logic [BIT_CNT_W-1:0]  bit_cnt_reg;
    logic [BIT_CNT_W-1:0]  dev_abs;
    logic [BIT_CNT_W-1:0]  phase_only_threshold;
    logic [BIT_CNT_W-1:0]  freq_only_threshold;
    csp_dev_e              dev_next;
    csp_dev_e              dev_reg;
    logic                  dev_fast_reg;

    logic [PCNT_W-1:0]     pcnt_reg;
    logic                  period_start;
    logic                  src_tape;
    logic                  src_fixed;
    logic [DUTY_W-1:0]     duty_sel;
    logic [DUTY_W-1:0]     duty_act_reg;
    logic [PCNT_W+DUTY_W-1:0] cmp_prod;
    logic [PCNT_W-1:0]     cmp_reg;
    logic                  mix_tgl_reg;
    logic                  force_now;
    logic                  out_next;

    // Pin inputs
    csp_sync u_sync_sleep (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (sleep_pin),
        .dout  (sleep_s)
    );
    csp_sync u_sync_frame (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (frame_pin),
        .dout  (frame_s)
    );
    csp_sync u_sync_bit (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (bit_pin),
        .dout  (bit_s)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_d_reg <= 1'b0;
            bit_d_reg   <= 1'b0;
        end else begin
            frame_d_reg <= frame_s;
            bit_d_reg   <= bit_s;
        end
    end
    assign frame_evt = frame_s & ~frame_d_reg;
    assign bit_evt   = bit_s & ~bit_d_reg;

    // Control register; reset clears tristate so the pin drives again
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg               <= MODE_PLAY_PLAY;
            cpu_duty_override      <= 1'b0;
            freq_regulation_enable <= 1'b0;
            narrow_band_select     <= 1'b0;
            pwm_output_tristate    <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            mode_reg               <= reg_wdata[CTRL_MODE_LSB +: 2];
            cpu_duty_override      <= reg_wdata[CTRL_OVR_BIT];
            freq_regulation_enable <= reg_wdata[CTRL_FREG_BIT];
            narrow_band_select     <= reg_wdata[CTRL_NBAND_BIT];
            pwm_output_tristate    <= reg_wdata[CTRL_HIZ_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_factor_register <= DUTY_RESET;
        end else if (reg_wr && reg_addr == REG_DUTY) begin
            duty_factor_register <= reg_wdata[DUTY_W-1:0];
        end
    end

    always_comb begin
        rdata_next = 32'h0;
        case (reg_addr)
            REG_CTRL: begin
                rdata_next[CTRL_MODE_LSB +: 2] = mode_reg;
                rdata_next[CTRL_OVR_BIT]       = cpu_duty_override;
                rdata_next[CTRL_FREG_BIT]      = freq_regulation_enable;
                rdata_next[CTRL_NBAND_BIT]     = narrow_band_select;
                rdata_next[CTRL_HIZ_BIT]       = pwm_output_tristate;
            end
            REG_DUTY: begin
                rdata_next[DUTY_W-1:0] = duty_factor_register;
            end
            REG_STATUS: begin
                rdata_next[STAT_DUTY_LSB +: DUTY_W] = tape_duty_reg;
                rdata_next[STAT_VALID_BIT]          = phase_valid_reg;
                rdata_next[STAT_CLASS_LSB +: 2]     = dev_reg;
                rdata_next[STAT_FAST_BIT]           = dev_fast_reg;
                rdata_next[STAT_OUT_BIT]            = speed_out;
                rdata_next[STAT_OE_BIT]             = speed_oe;
                rdata_next[STAT_SLEEP_BIT]          = sleep_s;
            end
            default: begin
                rdata_next = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Internal frame reference; one wrap per regulation interval
    assign ref_wrap = (ref_cnt_reg == RCNT_W'(UPDATE_PER - 1));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_cnt_reg <= '0;
        end else if (ref_wrap) begin
            ref_cnt_reg <= '0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 1'b1;
        end
    end

    // Offsetting by half an interval puts zero error at mid scale, and the
    // modulo wrap makes the characteristic a sawtooth past two blocks
    always_comb begin
        if (ref_cnt_reg >= RCNT_W'(UPDATE_PER - HALF)) begin
            phase_x_next = ref_cnt_reg - RCNT_W'(UPDATE_PER - HALF);
        end else begin
            phase_x_next = ref_cnt_reg + RCNT_W'(HALF);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_x_reg    <= RCNT_W'(HALF);
            frame_seen_reg <= 1'b0;
        end else if (frame_evt) begin
            // A frame on the wrap edge counts for the new interval
            phase_x_reg    <= phase_x_next;
            frame_seen_reg <= 1'b1;
        end else if (ref_wrap) begin
            frame_seen_reg <= 1'b0;
        end
    end

    assign phase_ok = frame_seen_reg
                      && (phase_x_reg >= RCNT_W'(HALF - PHASE_LIMIT))
                      && (phase_x_reg <= RCNT_W'(HALF + PHASE_LIMIT));
    assign duty_prod = 40'(phase_x_reg) * 40'(RCP_W'(RCP));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tape_duty_reg   <= DUTY_HALF;
            phase_valid_reg <= 1'b0;
        end else if (ref_wrap) begin
            phase_valid_reg <= phase_ok;
            if (phase_ok) begin
                tape_duty_reg <= duty_prod[37:30];
            end
        end
    end

    // Bit-rate measurement over the same interval
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt_reg <= '0;
        end else if (ref_wrap) begin
            bit_cnt_reg <= BIT_CNT_W'(bit_evt);
        end else if (bit_evt && bit_cnt_reg != '1) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    assign phase_only_threshold = narrow_band_select ? PTH_NARROW : PTH_WIDE;
    assign freq_only_threshold  = narrow_band_select ? FTH_NARROW : FTH_WIDE;
    assign dev_abs = (bit_cnt_reg > NOMINAL_CNT) ? bit_cnt_reg - NOMINAL_CNT
                                                 : NOMINAL_CNT - bit_cnt_reg;

    always_comb begin
        if (dev_abs < phase_only_threshold) begin
            dev_next = DEV_PHASE_ONLY;
        end else if (dev_abs > freq_only_threshold) begin
            dev_next = DEV_FREQ_ONLY;
        end else begin
            dev_next = DEV_MIXED;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dev_reg      <= DEV_PHASE_ONLY;
            dev_fast_reg <= 1'b0;
        end else if (ref_wrap) begin
            dev_reg      <= dev_next;
            dev_fast_reg <= (bit_cnt_reg > NOMINAL_CNT);
        end
    end

    // Source selection
    assign src_tape  = !cpu_duty_override
                       && (mode_reg == MODE_PLAY_PLAY || mode_reg == MODE_PLAY_RECORD);
    assign src_fixed = !cpu_duty_override && !src_tape;

    always_comb begin
        if (cpu_duty_override) begin
            duty_sel = duty_factor_register;
        end else if (src_tape) begin
            duty_sel = tape_duty_reg;
        end else begin
            duty_sel = DUTY_HALF;
        end
    end

    // PWM period counter
    assign period_start = (pcnt_reg == '0);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcnt_reg <= '0;
        end else if (pcnt_reg == PCNT_W'(PWM_PERIOD - 1)) begin
            pcnt_reg <= '0;
        end else begin
            pcnt_reg <= pcnt_reg + 1'b1;
        end
    end

    // Latching only at period start keeps each pulse whole
    assign cmp_prod = duty_sel * PCNT_W'(PWM_PERIOD);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_act_reg <= DUTY_HALF;
            cmp_reg      <= PCNT_W'(PWM_PERIOD / 2);
            mix_tgl_reg  <= 1'b0;
        end else if (period_start) begin
            duty_act_reg <= duty_sel;
            cmp_reg      <= cmp_prod[PCNT_W+DUTY_W-1:DUTY_W];
            mix_tgl_reg  <= ~mix_tgl_reg;
        end
    end

    // Forcing only with tape source and frequency regulation on
    always_comb begin
        force_now = 1'b0;
        if (src_tape && freq_regulation_enable) begin
            case (dev_reg)
                DEV_FREQ_ONLY: force_now = 1'b1;
                DEV_MIXED:     force_now = mix_tgl_reg;
                default:       force_now = 1'b0;
            endcase
        end
    end

    // Slow tape drives high to speed the capstan up
    assign out_next = force_now ? ~dev_fast_reg : (pcnt_reg < cmp_reg);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            speed_out <= 1'b0;
            speed_oe  <= 1'b1;
        end else if (!sleep_s) begin
            speed_out <= out_next;
            speed_oe  <= ~pwm_output_tristate;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_sleeping;
        sleep_s && $past(sleep_s);
    endsequence

    sequence s_force_cond;
        src_tape && freq_regulation_enable && dev_reg == DEV_FREQ_ONLY && !sleep_s;
    endsequence

    chk_tristate_drive: assert property (
        (!sleep_s && pwm_output_tristate) |=> !speed_oe)
        else $error("Speed pin still driven with tristate set");

    chk_reset_release: assert property (
        $past(!rst_n) |-> (speed_oe && !pwm_output_tristate))
        else $error("Speed pin not driven after reset");

    chk_sleep_freeze: assert property (
        s_sleeping |-> ($stable(speed_out) && $stable(speed_oe)))
        else $error("Speed output changed during sleep");

    chk_fixed_half: assert property (
        (period_start && src_fixed) |=> duty_act_reg == DUTY_HALF)
        else $error("Record mode duty not 50 percent");

    chk_cpu_source: assert property (
        (period_start && cpu_duty_override) |=> duty_act_reg == $past(duty_factor_register))
        else $error("Software duty not applied");

    chk_period_len: assert property (
        (period_start && $past(rst_n)) |-> $past(pcnt_reg) == PCNT_W'(PWM_PERIOD - 1))
        else $error("PWM period length wrong");

    chk_duty_hold: assert property (
        (!ref_wrap || !phase_ok) |=> $stable(tape_duty_reg))
        else $error("Tape duty changed between updates");

    chk_freq_force: assert property (
        s_force_cond |=> speed_out == !$past(dev_fast_reg))
        else $error("Frequency-only level wrong");

    chk_phase_only: assert property (
        (src_tape && !freq_regulation_enable && !sleep_s)
            |=> speed_out == ($past(pcnt_reg) < $past(cmp_reg)))
        else $error("Phase-only output forced");

    chk_glitch_free: assert property (
        !period_start |=> $stable(cmp_reg))
        else $error("Compare value changed mid period");

    chk_mixed_alt: assert property (
        (period_start && $past(rst_n)) |=> mix_tgl_reg != $past(mix_tgl_reg))
        else $error("Mixed gating not alternating");

endmodule

// File: rtl/csp_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to clk.
// Notes:   Output changes only once stages two and three agree.
module csp_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic ff1_reg;
    logic ff2_reg;
    logic ff3_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ff1_reg <= 1'b0;
            ff2_reg <= 1'b0;
            ff3_reg <= 1'b0;
        end else begin
            ff1_reg <= din;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dout <= 1'b0;
        end else if (ff2_reg == ff3_reg) begin
            dout <= ff3_reg;
        end
    end
endmodule

// File: verif/capstan_speed_pwm_test.sv
// Purpose: Self-checking bench for the capstan speed PWM block.
// Assumes: Shortened period 64, reference interval 2000, phase limit 825.
// Notes:   First bit pin idle (slow tape); second instance gets bit streams near nominal.
module capstan_speed_pwm_test import csp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 64;
    localparam int UPD = 2000;
    localparam int UPD2 = 8000;
    logic        clk = 1'b0;
    logic        rst_n;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        sleep_pin;
    logic        frame_pin;
    logic        bit_pin;
    logic        speed_out;
    logic        speed_oe;
    logic        speed_pin;
    logic [7:0]  meas_hi;
    logic [31:0] d;
    logic [31:0] d2;
    logic        o;
    logic        e;
    logic        bad;
    logic [31:0] rdata2;
    logic [31:0] r2;
    logic        bit2 = 1'b0;
    logic        slow_bits = 1'b1;
    int          bph = 0;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          ktab[5] = '{1600, 1800, 200, 400, 1000};
    int          xtab[5] = '{76, 102, 153, 179, 179};
    logic [7:0]  dtab[4] = '{8'h00, 8'h41, 8'hc0, 8'hff};

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;
    assign speed_pin = speed_oe ? speed_out : 1'b0;
    // Period 4 is about 2% slow, pattern 4-4-4-4-5 about 7% slow
    always @(posedge clk) begin
        bph  <= (bph >= (slow_bits ? 20 : 3)) ? 0 : bph + 1;
        bit2 <= !bph[1] && bph != 20;
    end

    csp_pwm #(.PWM_PERIOD(PER), .UPDATE_PER(UPD), .PHASE_LIMIT(825)) DUT (
        .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .sleep_pin(sleep_pin), .frame_pin(frame_pin),
        .bit_pin(bit_pin), .speed_out(speed_out), .speed_oe(speed_oe));
    csp_motor_model #(.WIN(PER)) motor (.clk(clk), .speed_pin(speed_pin), .meas_hi(meas_hi));
    // Longer interval so the bit count can come near nominal through the synchroniser
    csp_pwm #(.PWM_PERIOD(PER), .UPDATE_PER(UPD2), .PHASE_LIMIT(3300)) DUT2 (
        .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata2), .sleep_pin(sleep_pin), .frame_pin(frame_pin),
        .bit_pin(bit2), .speed_out(), .speed_oe());

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        n_checks++;
        if (g !== ex) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, ex, g);
        end
    endtask
    task automatic near(input string nm, input int ex, input logic [31:0] g, input int tol);
        n_checks++;
        if ($isunknown(g) || int'(g) > ex + tol || int'(g) < ex - tol) begin
            error_cnt++;
            $display("MISMATCH %s exp %0d got %0d", nm, ex, g);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        v = rdata;
        r2 = rdata2;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // Bounded wait for a point of the free-running reference interval
    task automatic wait_ref(input int k);
        int n;
        n = 0;
        while (cyc % UPD != k && n < UPD + 2) begin
            @(posedge clk);
            n++;
        end
        if (n >= UPD + 2) begin
            error_cnt++;
            $display("MISMATCH wait_ref exp %0d got timeout", k);
            end_of_test();
        end
    endtask

    initial begin
        {rst_n, addr, wdata, wr, rd, sleep_pin, frame_pin, bit_pin} = '0;
        do_reset();
        chk("oe_reset", 1, speed_oe);
        rd_reg(REG_CTRL, d);
        chk("ctrl_reset", 0, d);
        rd_reg(REG_DUTY, d);
        chk("duty_reset", 32'h80, d);
        rd_reg(4'hc, d);
        chk("unmapped", 0, d);
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 4; i++) begin
                wr_reg(REG_DUTY, 32'(dtab[i]));
                wr_reg(REG_CTRL, 32'(m) | 32'h4);
                repeat (200) @(posedge clk);
                chk("hi_override", (32'(dtab[i]) * PER) >> 8, 32'(meas_hi));
            end
        end
        for (int m = 2; m < 4; m++) begin
            wr_reg(REG_CTRL, 32'(m));
            repeat (200) @(posedge clk);
            chk("hi_fixed_half", PER / 2, 32'(meas_hi));
        end
        wr_reg(REG_CTRL, 32'h20);
        repeat (2) @(posedge clk);
        chk("oe_tristate", 0, speed_oe);
        do_reset();
        chk("oe_after_reset", 1, speed_oe);
        // Tristate written while asleep must not reach the pin until wake
        wr_reg(REG_DUTY, 32'h80);
        wr_reg(REG_CTRL, 32'h4);
        repeat (200) @(posedge clk);
        sleep_pin <= 1'b1;
        repeat (8) @(posedge clk);
        o = speed_out;
        e = speed_oe;
        bad = 1'b0;
        wr_reg(REG_CTRL, 32'h24);
        repeat (150) begin
            @(posedge clk);
            if (speed_out !== o || speed_oe !== e) bad = 1'b1;
        end
        chk("sleep_freeze", 0, bad);
        sleep_pin <= 1'b0;
        repeat (10) @(posedge clk);
        chk("oe_after_wake", 0, speed_oe);
        wr_reg(REG_CTRL, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wait_ref(ktab[i] - 4);
            frame_pin <= 1'b1;
            repeat (8) @(posedge clk);
            frame_pin <= 1'b0;
            wait_ref(20);
            rd_reg(REG_STATUS, d);
            near("tape_duty", xtab[i], d & 32'hff, 2);
            chk("phase_valid", 32'(i < 4), 32'(d[STAT_VALID_BIT]));
            repeat (200) @(posedge clk);
            near("hi_phase", (xtab[i] * PER) >> 8, 32'(meas_hi), 1);
        end
        wait_ref(1900);
        rd_reg(REG_STATUS, d2);
        chk("duty_held", d & 32'hff, d2 & 32'hff);
        for (int n = 0; n < 2; n++) begin
            wr_reg(REG_CTRL, 32'h8 | (32'(n) << 4));
            repeat (2 * UPD2 + 10) @(posedge clk);
            wait_ref(20);
            rd_reg(REG_STATUS, d);
            chk("dev_class", 2, 32'(d[10:9]));
            chk("dev_class_b", n ? 2 : 1, 32'(r2[10:9]));
            repeat (200) @(posedge clk);
            chk("hi_forced", PER, 32'(meas_hi));
        end
        slow_bits <= 1'b0;
        repeat (2 * UPD2 + 10) @(posedge clk);
        rd_reg(REG_STATUS, d);
        chk("dev_class_c", 0, 32'(r2[10:9]));
        end_of_test();
    end
endmodule

// File: verif/csp_motor_model.sv
// Purpose: Capstan motor driver model; measures speed pin high time.
// Assumes: Pin is pulled low while the block is not driving it.
// Notes:   Window equals the PWM period, so its alignment does not matter.
module csp_motor_model #(
    parameter int WIN = 64
) (
    input  wire logic       clk,
    input  wire logic       speed_pin,
    output logic      [7:0] meas_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] win_cnt = 8'h00;
    logic [7:0] hi_acc  = 8'h00;
    // High cycles per period stand for the drive level the motor sees
    always @(posedge clk) begin
        if (win_cnt == 8'(WIN - 1)) begin
            meas_hi <= hi_acc + 8'(speed_pin);
            hi_acc  <= 8'h00;
            win_cnt <= 8'h00;
        end else begin
            hi_acc  <= hi_acc + 8'(speed_pin);
            win_cnt <= win_cnt + 8'h01;
        end
    end
endmodule
